// ### rtl/mbc_pkg.sv
package mbc_pkg;

    // ========================================================================
    // Register numbers.
    localparam logic [9:0]  REG_TBL4_FIRST  = 10'h1E1;
    localparam logic [9:0]  REG_TBL4_LAST   = 10'h200;
    localparam logic [9:0]  REG_CODE_MASK   = 10'h2C1;
    localparam logic [9:0]  REG_SETPT_MASK  = 10'h2C2;
    localparam logic [9:0]  REG_VIEW_MASK   = 10'h2C3;
    localparam logic [9:0]  REG_MANUAL_VAL  = 10'h2C4;
    localparam logic [9:0]  REG_CAL_SPAN    = 10'h2C5;
    localparam logic [9:0]  REG_CAL_ZERO    = 10'h2C6;

    // ========================================================================
    // Values after reset and field layouts.
    localparam logic [15:0] CODE_MASK_RST   = 16'hFFFF;
    localparam logic [15:0] SETPT_MASK_RST  = 16'h1FFF;
    localparam logic [15:0] VIEW_MASK_RST   = 16'h7F7F;
    localparam logic [15:0] CODE_USED       = 16'h3FFE;
    localparam logic [15:0] SETPT_USED      = 16'h1FFF;
    localparam int          VIEW_DN_LSB     = 0;
    localparam int          VIEW_UP_LSB     = 8;
    localparam int          VIEW_DN_MACRO   = 7;
    localparam int          VIEW_UP_MACRO   = 15;
    localparam logic [15:0] VIEW_ITEMS      = 16'h007F;
    localparam logic [4:0]  ITEM_NONE       = 5'h10;
    localparam logic signed [31:0] TBL_MAX  = 32'sh007FFFFF;
    localparam logic signed [31:0] TBL_MIN  = -32'sh007FFFFF;

    // ========================================================================
    // Types.
    typedef enum logic [2:0]
    {
        SEQ_IDLE   = 3'b000,
        SEQ_CODE   = 3'b001,
        SEQ_SETPT  = 3'b010,
        SEQ_VIEWUP = 3'b011,
        SEQ_VIEWDN = 3'b100
    } mbc_seq_t;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [9:0]  num;
        logic [31:0] data;
    } mbc_req_t;

    typedef struct packed
    {
        logic        show;
        mbc_seq_t    seq;
        logic [3:0]  item;
    } mbc_menu_t;

endpackage

// ### rtl/mbc_menu_cal_regs.sv
`timescale 1ns/1ps
module mbc_menu_cal_regs
#(
    parameter int TBL_POINTS = 32
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire mbc_pkg::mbc_req_t req,
    input  wire logic              progBtn,
    input  wire logic              upBtn,
    input  wire logic              downBtn,
    output logic [31:0]            rdData_r,
    output logic                   rdValid_r,
    output mbc_pkg::mbc_menu_t     menu_r,
    output logic                   macroUp_r,
    output logic                   macroDn_r
);

    // ========================================================================
    // Functions.
    function automatic logic [4:0] firstSet(input logic [15:0] m,
                                            input logic [4:0]  from);
        logic [4:0] r;
        r = mbc_pkg::ITEM_NONE;
        for (int i = 15; i >= 0; i--)
        begin
            if (m[i] && (5'(i) >= from))
            begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] seqMask(input mbc_pkg::mbc_seq_t s,
                                            input logic [15:0] code,
                                            input logic [15:0] setpt,
                                            input logic [15:0] view);
        logic [15:0] m;
        m = 16'h0000;
        case (s)
            mbc_pkg::SEQ_CODE:   m = code & mbc_pkg::CODE_USED;
            mbc_pkg::SEQ_SETPT:  m = setpt & mbc_pkg::SETPT_USED;
            mbc_pkg::SEQ_VIEWUP: m = (view >> mbc_pkg::VIEW_UP_LSB)
                                     & mbc_pkg::VIEW_ITEMS;
            mbc_pkg::SEQ_VIEWDN: m = (view >> mbc_pkg::VIEW_DN_LSB)
                                     & mbc_pkg::VIEW_ITEMS;
            default:             m = 16'h0000;
        endcase
        return m;
    endfunction

    // ========================================================================
    // Storage.
    logic [15:0]        codeMask_r;
    logic [15:0]        codeMask_nxt;
    logic [15:0]        setptMask_r;
    logic [15:0]        setptMask_nxt;
    logic [15:0]        viewMask_r;
    logic [15:0]        viewMask_nxt;
    logic signed [31:0] manualVal_r;
    logic signed [31:0] manualVal_nxt;
    logic signed [31:0] calSpan_r;
    logic signed [31:0] calSpan_nxt;
    logic signed [31:0] calZero_r;
    logic signed [31:0] calZero_nxt;
    logic signed [23:0] tbl_r [TBL_POINTS];
    logic               tblWr;
    logic [4:0]         tblIdx;
    logic signed [23:0] tblVal;
    logic               tblHit;
    logic [31:0]        rdData_nxt;
    logic               rdValid_nxt;

    always_comb
    begin
        tblHit = (req.num >= mbc_pkg::REG_TBL4_FIRST) &&
                 (req.num <= mbc_pkg::REG_TBL4_FIRST + 10'(TBL_POINTS - 1));
        tblIdx = 5'(req.num - mbc_pkg::REG_TBL4_FIRST);
        tblWr = req.wr && tblHit;
        if ($signed(req.data) > mbc_pkg::TBL_MAX)
        begin
            tblVal = 24'(mbc_pkg::TBL_MAX);
        end
        else if ($signed(req.data) < mbc_pkg::TBL_MIN)
        begin
            tblVal = 24'(mbc_pkg::TBL_MIN);
        end
        else
        begin
            tblVal = req.data[23:0];
        end
        codeMask_nxt = codeMask_r;
        setptMask_nxt = setptMask_r;
        viewMask_nxt = viewMask_r;
        manualVal_nxt = manualVal_r;
        calSpan_nxt = calSpan_r;
        calZero_nxt = calZero_r;
        if (req.wr)
        begin
            if (req.num == mbc_pkg::REG_CODE_MASK)
            begin
                codeMask_nxt = req.data[15:0];
            end
            else if (req.num == mbc_pkg::REG_SETPT_MASK)
            begin
                setptMask_nxt = req.data[15:0];
            end
            else if (req.num == mbc_pkg::REG_VIEW_MASK)
            begin
                viewMask_nxt = req.data[15:0];
            end
            else if (req.num == mbc_pkg::REG_MANUAL_VAL)
            begin
                manualVal_nxt = req.data;
            end
            else if (req.num == mbc_pkg::REG_CAL_SPAN)
            begin
                calSpan_nxt = req.data;
            end
            else if (req.num == mbc_pkg::REG_CAL_ZERO)
            begin
                calZero_nxt = req.data;
            end
        end
        rdValid_nxt = req.rd;
        rdData_nxt = 32'h00000000;
        if (req.rd)
        begin
            if (tblHit)
            begin
                rdData_nxt = 32'(tbl_r[tblIdx]);
            end
            else if (req.num == mbc_pkg::REG_CODE_MASK)
            begin
                rdData_nxt = {16'h0000, codeMask_r};
            end
            else if (req.num == mbc_pkg::REG_SETPT_MASK)
            begin
                rdData_nxt = {16'h0000, setptMask_r};
            end
            else if (req.num == mbc_pkg::REG_VIEW_MASK)
            begin
                rdData_nxt = {16'h0000, viewMask_r};
            end
            else if (req.num == mbc_pkg::REG_MANUAL_VAL)
            begin
                rdData_nxt = manualVal_r;
            end
            else if (req.num == mbc_pkg::REG_CAL_SPAN)
            begin
                rdData_nxt = calSpan_r;
            end
            else if (req.num == mbc_pkg::REG_CAL_ZERO)
            begin
                rdData_nxt = calZero_r;
            end
        end
    end

    // Masks take defaults at reset; values and table points keep contents.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            codeMask_r <= mbc_pkg::CODE_MASK_RST;
            setptMask_r <= mbc_pkg::SETPT_MASK_RST;
            viewMask_r <= mbc_pkg::VIEW_MASK_RST;
            rdData_r <= 32'h00000000;
            rdValid_r <= 1'b0;
        end
        else
        begin
            codeMask_r <= codeMask_nxt;
            setptMask_r <= setptMask_nxt;
            viewMask_r <= viewMask_nxt;
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
        manualVal_r <= manualVal_nxt;
        calSpan_r <= calSpan_nxt;
        calZero_r <= calZero_nxt;
        if (tblWr)
        begin
            tbl_r[tblIdx] <= tblVal;
        end
    end

    // ========================================================================
    // Menu sequencing.
    logic               progPrev_r;
    logic               upPrev_r;
    logic               downPrev_r;
    logic               progE;
    logic               upE;
    logic               downE;
    mbc_pkg::mbc_menu_t menu_nxt;
    logic               macroUp_nxt;
    logic               macroDn_nxt;
    logic [15:0]        curMask;
    logic [4:0]         found;
    mbc_pkg::mbc_seq_t  target;
    logic               seek;
    logic [4:0]         from;

    always_comb
    begin
        progE = progBtn && !progPrev_r;
        upE = upBtn && !upPrev_r;
        downE = downBtn && !downPrev_r;
        curMask = seqMask(menu_r.seq, codeMask_r, setptMask_r, viewMask_r);
        menu_nxt = menu_r;
        macroUp_nxt = 1'b0;
        macroDn_nxt = 1'b0;
        seek = 1'b0;
        target = menu_r.seq;
        from = {1'b0, menu_r.item} + 5'h01;
        case (menu_r.seq)
            mbc_pkg::SEQ_IDLE:
            begin
                from = 5'h00;
                if (progBtn && upBtn && (progE || upE))
                begin
                    seek = 1'b1;
                    target = mbc_pkg::SEQ_CODE;
                end
                else if (progBtn && downBtn && (progE || downE))
                begin
                    seek = 1'b1;
                    target = mbc_pkg::SEQ_SETPT;
                end
                else if (upE && !progBtn)
                begin
                    macroUp_nxt = viewMask_r[mbc_pkg::VIEW_UP_MACRO];
                    seek = !viewMask_r[mbc_pkg::VIEW_UP_MACRO];
                    target = mbc_pkg::SEQ_VIEWUP;
                end
                else if (downE && !progBtn)
                begin
                    macroDn_nxt = viewMask_r[mbc_pkg::VIEW_DN_MACRO];
                    seek = !viewMask_r[mbc_pkg::VIEW_DN_MACRO];
                    target = mbc_pkg::SEQ_VIEWDN;
                end
            end
            mbc_pkg::SEQ_CODE, mbc_pkg::SEQ_SETPT:
            begin
                seek = progE && !upBtn && !downBtn;
            end
            mbc_pkg::SEQ_VIEWUP:
            begin
                seek = upE && !progBtn;
            end
            mbc_pkg::SEQ_VIEWDN:
            begin
                seek = downE && !progBtn;
            end
            default:
            begin
                seek = 1'b0;
            end
        endcase
        if (!seek && menu_r.show && !curMask[menu_r.item])
        begin
            seek = 1'b1;
            from = {1'b0, menu_r.item};
        end
        found = firstSet(seqMask(target, codeMask_r, setptMask_r,
                                 viewMask_r), from);
        if (seek)
        begin
            if (found == mbc_pkg::ITEM_NONE)
            begin
                menu_nxt.show = 1'b0;
                menu_nxt.seq = mbc_pkg::SEQ_IDLE;
                menu_nxt.item = 4'h0;
            end
            else
            begin
                menu_nxt.show = 1'b1;
                menu_nxt.seq = target;
                menu_nxt.item = found[3:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            progPrev_r <= 1'b0;
            upPrev_r <= 1'b0;
            downPrev_r <= 1'b0;
            menu_r <= '{show: 1'b0, seq: mbc_pkg::SEQ_IDLE, item: 4'h0};
            macroUp_r <= 1'b0;
            macroDn_r <= 1'b0;
        end
        else
        begin
            progPrev_r <= progBtn;
            upPrev_r <= upBtn;
            downPrev_r <= downBtn;
            menu_r <= menu_nxt;
            macroUp_r <= macroUp_nxt;
            macroDn_r <= macroDn_nxt;
        end
    end

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_wrNum(logic [9:0] n);
        req.wr && !req.rd && req.num == n;
    endsequence

    sequence s_rdNum(logic [9:0] n);
        req.rd && !req.wr && req.num == n;
    endsequence

    a_mask_defaults: assert property (
        $past(reset) |-> codeMask_r == mbc_pkg::CODE_MASK_RST &&
        setptMask_r == mbc_pkg::SETPT_MASK_RST &&
        viewMask_r == mbc_pkg::VIEW_MASK_RST)
        else $error("menu masks not at defaults after reset");

    a_code_store: assert property (
        s_wrNum(mbc_pkg::REG_CODE_MASK) ##1 s_rdNum(mbc_pkg::REG_CODE_MASK)
        |=> rdValid_r && rdData_r == {16'h0000, $past(req.data[15:0], 2)})
        else $error("code mask readback differs from write");

    a_code_entry: assert property (
        menu_r.seq == mbc_pkg::SEQ_IDLE && progBtn && upBtn &&
        (progE || upE) && (codeMask_r & mbc_pkg::CODE_USED) != 16'h0000
        |=> menu_r.show && menu_r.seq == mbc_pkg::SEQ_CODE)
        else $error("code menu not entered");

    a_setpt_entry: assert property (
        menu_r.seq == mbc_pkg::SEQ_IDLE && progBtn && downBtn && !upBtn &&
        (progE || downE) && (setptMask_r & mbc_pkg::SETPT_USED) == 16'h0000
        |=> !menu_r.show && menu_r.seq == mbc_pkg::SEQ_IDLE)
        else $error("empty setpoint menu was shown");

    a_shown_enabled: assert property (
        menu_r.show && !$past(req.wr) |-> curMask[menu_r.item])
        else $error("disabled menu item is shown");

    a_view_macro: assert property (
        menu_r.seq == mbc_pkg::SEQ_IDLE && upE && !progBtn &&
        viewMask_r[mbc_pkg::VIEW_UP_MACRO]
        |=> macroUp_r && !menu_r.show ##1 !macroUp_r)
        else $error("up view macro not started");

    a_table_range: assert property (
        req.wr && tblHit && !req.rd ##1 req.rd && !req.wr &&
        req.num == $past(req.num)
        |=> $signed(rdData_r) <= mbc_pkg::TBL_MAX &&
        $signed(rdData_r) >= mbc_pkg::TBL_MIN)
        else $error("table point outside range");

    a_manual_store: assert property (
        s_wrNum(mbc_pkg::REG_MANUAL_VAL) ##1 s_rdNum(mbc_pkg::REG_MANUAL_VAL)
        |=> rdData_r == $past(req.data, 2))
        else $error("manual loader value lost");

    a_span_store: assert property (
        s_wrNum(mbc_pkg::REG_CAL_SPAN) ##1 s_rdNum(mbc_pkg::REG_CAL_SPAN)
        |=> rdData_r == $past(req.data, 2))
        else $error("span value lost");

    a_zero_store: assert property (
        s_wrNum(mbc_pkg::REG_CAL_ZERO) ##1 s_rdNum(mbc_pkg::REG_CAL_ZERO)
        |=> rdData_r == $past(req.data, 2))
        else $error("zero value lost");

endmodule

// ### testbench/mbc_host_model.sv
`timescale 1ns/1ps
// ============================================================================
// Front panel buttons and configuration host.
module mbc_host_model
(
    input  wire logic          clk,
    input  wire logic [31:0]   rdData_r,
    input  wire logic          rdValid_r,
    input  wire logic          macroUp_r,
    input  wire logic          macroDn_r,
    output mbc_pkg::mbc_req_t  req,
    output logic               progBtn,
    output logic               upBtn,
    output logic               downBtn
);
    initial
    begin
        req = 44'h000_0000_0000;
        progBtn = 1'b0;
        upBtn = 1'b0;
        downBtn = 1'b0;
    end

    // ========================================================================
    // Register port, one strobe per access; idle lines carry no stale value.
    task automatic write_reg(input logic [9:0] num, input logic [31:0] data);
        @(posedge clk);
        #1;
        req.wr = 1'b1;
        req.num = num;
        req.data = data;
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.num = ~num;
        req.data = ~data;
    endtask

    task automatic read_reg(input logic [9:0] num, output logic [31:0] data,
                            output logic valid);
        @(posedge clk);
        #1;
        req.rd = 1'b1;
        req.num = num;
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        req.num = ~num;
        data = rdData_r;
        valid = rdValid_r;
    endtask

    // Write followed at once by a read of the same register.
    task automatic write_read(input logic [9:0] num,
                              input logic [31:0] data,
                              output logic [31:0] got);
        @(posedge clk);
        #1;
        req.wr = 1'b1;
        req.num = num;
        req.data = data;
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b1;
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        req.num = ~num;
        req.data = ~data;
        got = rdData_r;
    endtask

    // ========================================================================
    // Button press, held four cycles, macro pulses caught while held.
    task automatic press(input logic p, input logic u, input logic d,
                         output logic mUp, output logic mDn);
        mUp = 1'b0;
        mDn = 1'b0;
        @(posedge clk);
        #1;
        progBtn = p;
        upBtn = u;
        downBtn = d;
        repeat (4)
        begin
            @(posedge clk);
            #1;
            mUp = mUp | macroUp_r;
            mDn = mDn | macroDn_r;
        end
        progBtn = 1'b0;
        upBtn = 1'b0;
        downBtn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("FAIL %0t got %h exp %h", $time, got, exp); \
        end \
    end
// ============================================================================
// Testbench top.
module testbench;
    logic               clk = 1'b0;
    logic               reset = 1'b1;
    mbc_pkg::mbc_req_t  req;
    logic               progBtn;
    logic               upBtn;
    logic               downBtn;
    logic [31:0]        rdData_r;
    logic               rdValid_r;
    mbc_pkg::mbc_menu_t menu_r;
    logic               macroUp_r;
    logic               macroDn_r;
    int                 fail_count = 0;
    int                 n_checks = 0;
    int                 cycles = 0;
    logic               mu;
    logic               md;

    always #2 clk = ~clk;

    mbc_menu_cal_regs #(.TBL_POINTS(32)) DUT
    (
        .clk(clk), .reset(reset), .req(req), .progBtn(progBtn),
        .upBtn(upBtn), .downBtn(downBtn), .rdData_r(rdData_r),
        .rdValid_r(rdValid_r), .menu_r(menu_r), .macroUp_r(macroUp_r),
        .macroDn_r(macroDn_r)
    );

    mbc_host_model host
    (
        .clk(clk), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
        .macroUp_r(macroUp_r), .macroDn_r(macroDn_r), .req(req),
        .progBtn(progBtn), .upBtn(upBtn), .downBtn(downBtn)
    );

    // ========================================================================
    // Shared checks.
    task automatic check_reg(input logic [9:0] num, input logic [31:0] exp);
        logic [31:0] data;
        logic        valid;
        host.read_reg(num, data, valid);
        `CHK(valid, 1'b1)
        `CHK(data, exp)
    endtask

    task automatic go(input logic p, input logic u, input logic d,
                      input logic show, input mbc_pkg::mbc_seq_t seq,
                      input logic [3:0] item);
        host.press(p, u, d, mu, md);
        `CHK(menu_r.show, show)
        if (show)
        begin
            `CHK(menu_r.seq, seq)
            `CHK(menu_r.item, item)
        end
    endtask

    // ========================================================================
    // Scenarios.
    task automatic test_defaults();
        check_reg(mbc_pkg::REG_CODE_MASK, 32'h0000FFFF);
        check_reg(mbc_pkg::REG_SETPT_MASK, 32'h00001FFF);
        check_reg(mbc_pkg::REG_VIEW_MASK, 32'h00007F7F);
    endtask

    task automatic test_wide_regs();
        host.write_reg(mbc_pkg::REG_MANUAL_VAL, 32'h80000001);
        host.write_reg(mbc_pkg::REG_CAL_SPAN, 32'h7FFFFFFF);
        host.write_reg(mbc_pkg::REG_CAL_ZERO, 32'hFFFFFFFE);
        host.write_reg(10'h2C7, 32'h12345678);
        check_reg(mbc_pkg::REG_MANUAL_VAL, 32'h80000001);
        check_reg(mbc_pkg::REG_CAL_SPAN, 32'h7FFFFFFF);
        check_reg(mbc_pkg::REG_CAL_ZERO, 32'hFFFFFFFE);
        check_reg(10'h2C7, 32'h00000000);
    endtask

    task automatic test_table();
        host.write_reg(mbc_pkg::REG_TBL4_FIRST, 32'hFF800001);
        host.write_reg(mbc_pkg::REG_TBL4_LAST, 32'h007FFFFF);
        host.write_reg(10'h1F0, 32'h00123456);
        check_reg(mbc_pkg::REG_TBL4_FIRST, 32'hFF800001);
        check_reg(mbc_pkg::REG_TBL4_LAST, 32'h007FFFFF);
        check_reg(10'h1F0, 32'h00123456);
        host.write_reg(mbc_pkg::REG_TBL4_FIRST, 32'hFF800000);
        host.write_reg(mbc_pkg::REG_TBL4_LAST, 32'h01000000);
        check_reg(mbc_pkg::REG_TBL4_FIRST, 32'hFF800001);
        check_reg(mbc_pkg::REG_TBL4_LAST, 32'h007FFFFF);
        check_reg(10'h201, 32'h00000000);
    endtask

    task automatic test_back_to_back();
        logic [31:0] got;
        host.write_read(mbc_pkg::REG_CAL_SPAN, 32'h00C0FFEE, got);
        `CHK(got, 32'h00C0FFEE)
        host.write_read(mbc_pkg::REG_CAL_ZERO, 32'hFFFF0001, got);
        `CHK(got, 32'hFFFF0001)
        host.write_read(mbc_pkg::REG_MANUAL_VAL, 32'h00000123, got);
        `CHK(got, 32'h00000123)
        host.write_read(mbc_pkg::REG_CODE_MASK, 32'h0000FFFF, got);
        `CHK(got, 32'h0000FFFF)
        host.write_read(mbc_pkg::REG_TBL4_FIRST, 32'h80000000, got);
        `CHK(got, 32'hFF800001)
    endtask

    task automatic test_code_menu();
        go(1'b1, 1'b1, 1'b0, 1'b1, mbc_pkg::SEQ_CODE, 4'h1);
        for (int i = 2; i <= 13; i++)
        begin
            go(1'b1, 1'b0, 1'b0, 1'b1, mbc_pkg::SEQ_CODE, 4'(i));
        end
        go(1'b1, 1'b0, 1'b0, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
        host.write_reg(mbc_pkg::REG_CODE_MASK, 32'h0000E009);
        check_reg(mbc_pkg::REG_CODE_MASK, 32'h0000E009);
        go(1'b1, 1'b1, 1'b0, 1'b1, mbc_pkg::SEQ_CODE, 4'h3);
        go(1'b0, 1'b1, 1'b0, 1'b1, mbc_pkg::SEQ_CODE, 4'h3);
        go(1'b1, 1'b0, 1'b0, 1'b1, mbc_pkg::SEQ_CODE, 4'hD);
        go(1'b1, 1'b0, 1'b0, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
        host.write_reg(mbc_pkg::REG_CODE_MASK, 32'h0000C001);
        go(1'b1, 1'b1, 1'b0, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
    endtask

    task automatic test_setpt_menu();
        go(1'b1, 1'b0, 1'b1, 1'b1, mbc_pkg::SEQ_SETPT, 4'h0);
        for (int i = 1; i <= 12; i++)
        begin
            go(1'b1, 1'b0, 1'b0, 1'b1, mbc_pkg::SEQ_SETPT, 4'(i));
        end
        go(1'b1, 1'b0, 1'b0, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
        host.write_reg(mbc_pkg::REG_SETPT_MASK, 32'h0000F081);
        go(1'b1, 1'b0, 1'b1, 1'b1, mbc_pkg::SEQ_SETPT, 4'h0);
        go(1'b1, 1'b0, 1'b0, 1'b1, mbc_pkg::SEQ_SETPT, 4'h7);
        go(1'b1, 1'b0, 1'b0, 1'b1, mbc_pkg::SEQ_SETPT, 4'hC);
        go(1'b1, 1'b0, 1'b0, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
    endtask

    task automatic test_view_menu();
        for (int i = 0; i <= 6; i++)
        begin
            go(1'b0, 1'b1, 1'b0, 1'b1, mbc_pkg::SEQ_VIEWUP, 4'(i));
            `CHK(mu, 1'b0)
        end
        go(1'b0, 1'b1, 1'b0, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
        host.write_reg(mbc_pkg::REG_VIEW_MASK, 32'h00000041);
        go(1'b0, 1'b0, 1'b1, 1'b1, mbc_pkg::SEQ_VIEWDN, 4'h0);
        go(1'b1, 1'b0, 1'b0, 1'b1, mbc_pkg::SEQ_VIEWDN, 4'h0);
        go(1'b0, 1'b0, 1'b1, 1'b1, mbc_pkg::SEQ_VIEWDN, 4'h6);
        go(1'b0, 1'b0, 1'b1, 1'b0, mbc_pkg::SEQ_IDLE, 4'h0);
        host.write_reg(mbc_pkg::REG_VIEW_MASK, 32'h00008080);
        host.press(1'b0, 1'b1, 1'b0, mu, md);
        `CHK({mu, md}, 2'b10)
        host.press(1'b0, 1'b0, 1'b1, mu, md);
        `CHK({mu, md}, 2'b01)
    endtask

    // ========================================================================
    // Verdict and run control.
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        test_defaults();
        test_wide_regs();
        test_table();
        test_back_to_back();
        test_code_menu();
        test_setpt_menu();
        test_view_menu();
        final_report();
    end
endmodule
